// ### rtl/bbrc_defs.svh
/*
  Offsets, field positions, reset values and decode constants of the
  buck-boost reference and mode control block.
  Assumes inclusion by bare name from the block's design files.
*/
`ifndef BBRC_DEFS_SVH
`define BBRC_DEFS_SVH

// Register offsets
`define BBRC_OFS_ENABLE 8'h00
`define BBRC_OFS_TARGET 8'h01
`define BBRC_OFS_FINE 8'h03
`define BBRC_OFS_GM 8'h04
`define BBRC_OFS_STATUS 8'h05

// Field positions
`define BBRC_EN_BIT 0
`define BBRC_FINE_BIT 4
`define BBRC_FREQ_MSB 2
`define BBRC_GM_MSB 2
`define BBRC_ST_REG_BIT 0
`define BBRC_ST_BOOST_BIT 1
`define BBRC_ST_PIN_BIT 2

// Reset values
`define BBRC_RST_ENABLE 8'h01
`define BBRC_RST_TARGET 8'h32
`define BBRC_RST_FINE 8'h00
`define BBRC_RST_GM 3'h5

// Reference step in mV per code of the 9-bit combined code
`define BBRC_REF_HALF_STEP_MV 12'h005

// Transconductance per code, microsiemens
`define BBRC_GM_US0 10'd87
`define BBRC_GM_US1 10'd100
`define BBRC_GM_US2 10'd117
`define BBRC_GM_US3 10'd333
`define BBRC_GM_US4 10'd400
`define BBRC_GM_US5 10'd500
`define BBRC_GM_US6 10'd667
`define BBRC_GM_US7 10'd1000

// Ramp midpoint of the 8-bit compensation scale
`define BBRC_RAMP_MID 8'h80
`define BBRC_RAMP_TOP 8'hFF

`endif

// ### rtl/bbrc_i2c_slave.sv
/*
  Two-wire management bus slave: address match, register pointer,
  burst writes and burst reads with auto-increment.
  Assumes scl and sda are open-drain pins pulled up outside; the bus
  clock is far slower than clock_i so edges are seen by sampling.
*/
`timescale 1ns/1ps

module bbrc_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary value
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Register side
  output bbrc_pkg::bbrc_wr_t wr_o,
  output logic [7:0] rd_addr_o,
  input wire logic [7:0] rd_data_i
);

  logic [2:0] scl_s_r;
  logic [2:0] sda_s_r;
  bbrc_pkg::bbrc_i2c_st_t st_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  logic [7:0] ptr_r;
  logic rw_r;
  logic nack_r;
  bbrc_pkg::bbrc_wr_t wr_r;

  // Stage 0 is read only by stage 1; edges use stages 1 and 2
  wire scl_rise = scl_s_r[1] & ~scl_s_r[2];
  wire scl_fall = ~scl_s_r[1] & scl_s_r[2];
  wire start_det = scl_s_r[1] & scl_s_r[2] & ~sda_s_r[1] & sda_s_r[2];
  wire stop_det = scl_s_r[1] & scl_s_r[2] & sda_s_r[1] & ~sda_s_r[2];
  wire byte_done = (cnt_r == 4'h8);
  wire addr_hit = (sh_r[7:1] == DEV_ADDR);
  wire ack_st = (st_r == bbrc_pkg::BBRC_I2C_ACKA) | (st_r == bbrc_pkg::BBRC_I2C_ACKP)
              | (st_r == bbrc_pkg::BBRC_I2C_ACKW);
  wire rd_low = (st_r == bbrc_pkg::BBRC_I2C_RDATA) & ~tx_r[7];

  assign sda_o = 1'b0;
  assign sda_oe_o = ack_st | rd_low;
  assign wr_o = wr_r;
  assign rd_addr_o = ptr_r;

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
    end else begin
      scl_s_r <= {scl_s_r[1:0], scl_i};
      sda_s_r <= {sda_s_r[1:0], sda_i};
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      st_r <= bbrc_pkg::BBRC_I2C_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'hFF;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
      wr_r <= '0;
    end else begin
      wr_r.strobe <= 1'b0;
      if (start_det) begin
        st_r <= bbrc_pkg::BBRC_I2C_ADDR;
        cnt_r <= 4'h0;
      end else if (stop_det) begin
        st_r <= bbrc_pkg::BBRC_I2C_IDLE;
      end else if (scl_rise) begin
        sh_r <= {sh_r[6:0], sda_s_r[1]};
        cnt_r <= cnt_r + 4'h1;
        if (st_r == bbrc_pkg::BBRC_I2C_RACK) begin
          nack_r <= sda_s_r[1];
          if (!sda_s_r[1]) begin
            ptr_r <= ptr_r + 8'h01;
          end
        end
      end else if (scl_fall) begin
        unique case (st_r)
          bbrc_pkg::BBRC_I2C_IDLE: begin
          end
          bbrc_pkg::BBRC_I2C_ADDR: begin
            if (byte_done) begin
              st_r <= addr_hit ? bbrc_pkg::BBRC_I2C_ACKA : bbrc_pkg::BBRC_I2C_IDLE;
              rw_r <= sh_r[0];
            end
          end
          bbrc_pkg::BBRC_I2C_ACKA: begin
            cnt_r <= 4'h0;
            tx_r <= rd_data_i;
            st_r <= rw_r ? bbrc_pkg::BBRC_I2C_RDATA : bbrc_pkg::BBRC_I2C_PTR;
          end
          bbrc_pkg::BBRC_I2C_PTR: begin
            if (byte_done) begin
              ptr_r <= sh_r;
              st_r <= bbrc_pkg::BBRC_I2C_ACKP;
            end
          end
          bbrc_pkg::BBRC_I2C_ACKP: begin
            cnt_r <= 4'h0;
            st_r <= bbrc_pkg::BBRC_I2C_WDATA;
          end
          bbrc_pkg::BBRC_I2C_WDATA: begin
            if (byte_done) begin
              wr_r <= '{strobe: 1'b1, addr: ptr_r, data: sh_r};
              st_r <= bbrc_pkg::BBRC_I2C_ACKW;
            end
          end
          bbrc_pkg::BBRC_I2C_ACKW: begin
            cnt_r <= 4'h0;
            ptr_r <= ptr_r + 8'h01;
            st_r <= bbrc_pkg::BBRC_I2C_WDATA;
          end
          bbrc_pkg::BBRC_I2C_RDATA: begin
            if (byte_done) begin
              st_r <= bbrc_pkg::BBRC_I2C_RACK;
            end else begin
              tx_r <= {tx_r[6:0], 1'b1};
            end
          end
          bbrc_pkg::BBRC_I2C_RACK: begin
            cnt_r <= 4'h0;
            tx_r <= rd_data_i;
            st_r <= nack_r ? bbrc_pkg::BBRC_I2C_IDLE : bbrc_pkg::BBRC_I2C_RDATA;
          end
          default: begin
            st_r <= bbrc_pkg::BBRC_I2C_IDLE;
          end
        endcase
      end
    end
  end

endmodule : bbrc_i2c_slave

// ### rtl/bbrc_pkg.sv
/*
  Types shared by the buck-boost reference and mode control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package bbrc_pkg;

  typedef struct packed {
    logic strobe;
    logic [7:0] addr;
    logic [7:0] data;
  } bbrc_wr_t;

  typedef struct packed {
    logic input_high_switch;
    logic input_low_switch;
    logic output_low_switch;
    logic output_high_switch;
  } bbrc_sw_t;

  typedef enum logic [3:0] {
    BBRC_I2C_IDLE = 4'h0,
    BBRC_I2C_ADDR = 4'h1,
    BBRC_I2C_ACKA = 4'h3,
    BBRC_I2C_PTR = 4'h2,
    BBRC_I2C_ACKP = 4'h6,
    BBRC_I2C_WDATA = 4'h7,
    BBRC_I2C_ACKW = 4'h5,
    BBRC_I2C_RDATA = 4'h4,
    BBRC_I2C_RACK = 4'hC
  } bbrc_i2c_st_t;

endpackage : bbrc_pkg

// ### rtl/bbrc_top.sv
/*
  Reference and mode control of a four-switch buck-boost converter:
  register file behind the management bus, reference decode, error
  amplifier gain select, enable logic, dual ramps and switch patterns.
  Assumes comp_code_i comes from same-clock logic (a sampled
  compensation level) and that gate drivers add their own dead time.
*/
`timescale 1ns/1ps
`include "bbrc_defs.svh"

module bbrc_top #(
  parameter logic [6:0] DEV_ADDR = 7'h2A, // Arbitrary value
  parameter int COMP_W = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Management bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Enable pin and loop input
  input wire logic enable_pin_i,
  input wire logic [COMP_W-1:0] comp_code_i,
  // Reference, amplifier and frequency select
  output logic [8:0] ref_code_o,
  output logic [11:0] ref_mv_o,
  output logic [2:0] gm_select_o,
  output logic [9:0] gm_us_o,
  output logic [2:0] freq_sel_o,
  // Power stage
  output bbrc_pkg::bbrc_sw_t switch_o,
  output logic boost_mode_o,
  output logic regulating_o
);

  initial begin
    if (COMP_W != 8) begin
      $error("bbrc_top: COMP_W must be 8");
    end
  end

  function automatic logic [11:0] ref_decode(input logic [8:0] code);
    logic [20:0] prod;
    prod = 21'(code) * 21'(`BBRC_REF_HALF_STEP_MV);
    return prod[11:0];
  endfunction : ref_decode

  function automatic logic [9:0] gm_decode(input logic [2:0] code);
    logic [9:0] us;
    us = `BBRC_GM_US0;
    unique case (code)
      3'h0: us = `BBRC_GM_US0;
      3'h1: us = `BBRC_GM_US1;
      3'h2: us = `BBRC_GM_US2;
      3'h3: us = `BBRC_GM_US3;
      3'h4: us = `BBRC_GM_US4;
      3'h5: us = `BBRC_GM_US5;
      3'h6: us = `BBRC_GM_US6;
      3'h7: us = `BBRC_GM_US7;
    endcase
    return us;
  endfunction : gm_decode

  bbrc_pkg::bbrc_wr_t wr;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;

  bbrc_i2c_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_bus (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .wr_o(wr),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data)
  );

  logic [7:0] enable_r;
  logic [7:0] target_r;
  logic [7:0] fine_r;
  logic [2:0] gm_r;
  logic [1:0] pin_s_r;
  logic [8:0] ref_code_r;
  logic [11:0] ref_mv_r;
  logic [9:0] gm_us_r;
  logic [7:0] ramp_r;
  logic ramp_up_r;
  bbrc_pkg::bbrc_sw_t sw_r;
  bbrc_pkg::bbrc_sw_t sw_nxt;
  logic boost_r;
  logic regulating_r;

  // Register decode
  wire wr_en = wr.strobe & (wr.addr == `BBRC_OFS_ENABLE);
  wire wr_tgt = wr.strobe & (wr.addr == `BBRC_OFS_TARGET);
  wire wr_fine = wr.strobe & (wr.addr == `BBRC_OFS_FINE);
  wire wr_gm = wr.strobe & (wr.addr == `BBRC_OFS_GM);
  wire pin_en = pin_s_r[1];
  wire [7:0] status_w = {5'h00, pin_en, boost_r, regulating_r};
  wire hit_en = (rd_addr == `BBRC_OFS_ENABLE);
  wire hit_tgt = (rd_addr == `BBRC_OFS_TARGET);
  wire hit_fine = (rd_addr == `BBRC_OFS_FINE);
  wire hit_gm = (rd_addr == `BBRC_OFS_GM);
  wire hit_st = (rd_addr == `BBRC_OFS_STATUS);

  // Unmapped offsets read as zero
  assign rd_data = hit_en ? enable_r :
                   hit_tgt ? target_r :
                   hit_fine ? fine_r :
                   hit_gm ? {5'h00, gm_r} :
                   hit_st ? status_w : 8'h00;

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      enable_r <= `BBRC_RST_ENABLE;
      target_r <= `BBRC_RST_TARGET;
      fine_r <= `BBRC_RST_FINE;
      gm_r <= `BBRC_RST_GM;
    end else begin
      // Reserved low codes are stored as written; the host keeps clear of them
      if (wr_tgt) target_r <= wr.data;
      if (wr_fine) fine_r <= wr.data;
      if (wr_en) enable_r <= wr.data;
      if (wr_gm) gm_r <= wr.data[`BBRC_GM_MSB:0];
    end
  end

  // Enable pin is asynchronous to the switching clock
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      pin_s_r <= 2'h0;
    end else begin
      pin_s_r <= {pin_s_r[0], enable_pin_i};
    end
  end

  // Combined code and reference level, one cycle behind the register write
  wire [8:0] ref_code_nxt = {target_r, fine_r[`BBRC_FINE_BIT]};
  wire [11:0] ref_mv_nxt = ref_decode(ref_code_nxt);

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ref_code_r <= {`BBRC_RST_TARGET, 1'b0};
      ref_mv_r <= ref_decode({`BBRC_RST_TARGET, 1'b0});
      gm_us_r <= gm_decode(`BBRC_RST_GM);
    end else begin
      ref_code_r <= ref_code_nxt;
      ref_mv_r <= ref_mv_nxt;
      gm_us_r <= gm_decode(gm_r);
    end
  end

  // Triangle ramp; its mirror is the second ramp, 180 degrees apart
  wire [7:0] ramp_a = ramp_r;
  wire [7:0] ramp_b = `BBRC_RAMP_TOP - ramp_r;
  wire ramp_turn = ramp_up_r ? (ramp_r == `BBRC_RAMP_TOP) : (ramp_r == 8'h00);

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ramp_r <= 8'h00;
      ramp_up_r <= 1'b1;
    end else begin
      if (ramp_turn) begin
        ramp_up_r <= ~ramp_up_r;
      end else begin
        ramp_r <= ramp_up_r ? ramp_r + 8'h01 : ramp_r - 8'h01;
      end
    end
  end

  // Duty scales so buck reaches full duty where boost starts at zero
  wire regulating_nxt = enable_r[`BBRC_EN_BIT] & pin_en;
  wire boost_nxt = (comp_code_i > `BBRC_RAMP_MID);
  wire [7:0] buck_lvl = {comp_code_i[6:0], 1'b0};
  wire [7:0] comp_over = comp_code_i - `BBRC_RAMP_MID;
  wire [7:0] boost_lvl = {comp_over[6:0], 1'b0};
  wire buck_on = (comp_code_i >= `BBRC_RAMP_MID) | (buck_lvl > ramp_a);
  wire boost_on = boost_lvl > ramp_b;

  always_comb begin
    sw_nxt = '0;
    if (!regulating_nxt) begin
      sw_nxt = '0;
    end else if (boost_nxt) begin
      sw_nxt.input_high_switch = 1'b1;
      sw_nxt.input_low_switch = 1'b0;
      sw_nxt.output_low_switch = boost_on;
      sw_nxt.output_high_switch = ~boost_on;
    end else begin
      sw_nxt.output_high_switch = 1'b1;
      sw_nxt.output_low_switch = 1'b0;
      sw_nxt.input_high_switch = buck_on;
      sw_nxt.input_low_switch = ~buck_on;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      sw_r <= '0;
      boost_r <= 1'b0;
      regulating_r <= 1'b0;
    end else begin
      sw_r <= sw_nxt;
      boost_r <= regulating_nxt & boost_nxt;
      regulating_r <= regulating_nxt;
    end
  end

  assign ref_code_o = ref_code_r;
  assign ref_mv_o = ref_mv_r;
  assign gm_select_o = gm_r;
  assign gm_us_o = gm_us_r;
  assign freq_sel_o = fine_r[`BBRC_FREQ_MSB:0];
  assign switch_o = sw_r;
  assign boost_mode_o = boost_r;
  assign regulating_o = regulating_r;

endmodule : bbrc_top

// ### verif/bbrc_i2c_host.sv
/*
  Management bus host model: start, stop, bytes, register write and read.
  Assumes the bench resolves sda with a pull-up from all drivers.
*/
`timescale 1ns/1ps

module bbrc_i2c_host (
  // Clock
  input wire logic clock_i,
  // Bus pins
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic q();
    repeat (6) @(posedge clock_i);
  endtask : q
  // Data moves only mid-low so the slave never sees a false start
  task automatic put_bit(input logic b);
    q();
    sda_low_o <= !b;
    q();
    scl_o <= 1'b1;
    q();
    q();
    scl_o <= 1'b0;
  endtask : put_bit
  task automatic get_bit(output logic b);
    q();
    sda_low_o <= 1'b0;
    q();
    scl_o <= 1'b1;
    q();
    b = sda_i;
    q();
    scl_o <= 1'b0;
  endtask : get_bit
  task automatic start();
    q();
    sda_low_o <= 1'b0;
    q();
    scl_o <= 1'b1;
    q();
    sda_low_o <= 1'b1;
    q();
    scl_o <= 1'b0;
  endtask : start
  task automatic stop();
    q();
    sda_low_o <= 1'b1;
    q();
    scl_o <= 1'b1;
    q();
    sda_low_o <= 1'b0;
    q();
  endtask : stop
  task automatic put_byte(input logic [7:0] v, inout logic ok);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(v[i]);
    get_bit(a);
    ok = ok & !a;
  endtask : put_byte
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
                           output logic ok);
    ok = 1'b1;
    start();
    put_byte({dev, 1'b0}, ok);
    put_byte(a, ok);
    put_byte(d, ok);
    stop();
  endtask : write_reg
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d,
                          output logic ok);
    ok = 1'b1;
    start();
    put_byte({dev, 1'b0}, ok);
    put_byte(a, ok);
    start();
    put_byte({dev, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(1'b1);
    stop();
  endtask : read_reg
endmodule : bbrc_i2c_host

// ### verif/bbrc_top_properties.sv
/*
  Port checks of the reference and mode control top.
  Assumes it is bound onto every bbrc_top instance.
*/
`timescale 1ns/1ps

module bbrc_top_properties #(
  parameter int COMP_W = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Watched ports
  input wire logic enable_pin_i,
  input wire logic [COMP_W-1:0] comp_code_i,
  input wire logic [8:0] ref_code_o,
  input wire logic [11:0] ref_mv_o,
  input wire logic [2:0] gm_select_o,
  input wire logic [9:0] gm_us_o,
  input wire bbrc_pkg::bbrc_sw_t switch_o,
  input wire logic boost_mode_o,
  input wire logic regulating_o
);
  localparam logic [9:0] GM_T [8] = '{10'h057, 10'h064, 10'h075, 10'h14D,
    10'h190, 10'h1F4, 10'h29B, 10'h3E8};
  wire logic ih = switch_o.input_high_switch;
  wire logic il = switch_o.input_low_switch;
  wire logic ol = switch_o.output_low_switch;
  wire logic oh = switch_o.output_high_switch;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  ref_scale_a: assert property (ref_mv_o == 12'(ref_code_o) * 12'h005)
    else $error("reference mV not five per code");
  // The microsiemens value is registered one cycle behind the field
  gm_decode_a: assert property (gm_us_o == GM_T[$past(gm_select_o)])
    else $error("gm value does not match its code");
  reset_values_a: assert property ($rose(resetn_i) |->
    ref_code_o == 9'h064 && gm_select_o == 3'h5)
    else $error("wrong values out of reset");
  // Two idle cycles are required, though the switch register clears on the same edge as regulating_o
  off_switches_a: assert property (!regulating_o && !$past(regulating_o) |->
    switch_o == 4'h0)
    else $error("switch on while not regulating");
  pin_disable_a: assert property (!enable_pin_i [*4] |=> !regulating_o)
    else $error("still regulating with pin low");
  boost_shape_a: assert property (regulating_o && $past(regulating_o) &&
    $past(comp_code_i) > 8'h80 |-> ih && !il && ol != oh)
    else $error("boost pattern broken");
  buck_shape_a: assert property (regulating_o && $past(regulating_o) &&
    $past(comp_code_i) <= 8'h80 |-> oh && !ol && ih != il)
    else $error("buck pattern broken");
  mode_flag_a: assert property (regulating_o && $past(regulating_o) |->
    boost_mode_o == ($past(comp_code_i) > 8'h80))
    else $error("mode flag disagrees with comp");
endmodule : bbrc_top_properties

bind bbrc_top bbrc_top_properties #(.COMP_W(COMP_W)) props_i (
  .clock_i(clock_i), .resetn_i(resetn_i), .enable_pin_i(enable_pin_i),
  .comp_code_i(comp_code_i), .ref_code_o(ref_code_o), .ref_mv_o(ref_mv_o),
  .gm_select_o(gm_select_o), .gm_us_o(gm_us_o), .switch_o(switch_o),
  .boost_mode_o(boost_mode_o), .regulating_o(regulating_o));

// ### verif/bbrc_top_test.sv
/*
  Self-checking bench of the reference and mode control top.
  Assumes the design files and the host model are compiled first.
*/
`timescale 1ns/1ps

module bbrc_top_test;
  localparam logic [6:0] DEV = 7'h2A; // Arbitrary value
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic enable_pin_i = 1'b1;
  logic [7:0] comp_code_i = 8'h40;
  logic scl, host_low, sda_oe, boost, reg_on, ok;
  logic [8:0] ref_code;
  logic [11:0] ref_mv;
  logic [2:0] gm_sel;
  logic [2:0] freq;
  logic [9:0] gm_us;
  logic [7:0] rd;
  bbrc_pkg::bbrc_sw_t sw;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  // Host keeps to codes of 100 mV and up
  logic [7:0] codes [4] = '{8'h0A, 8'h32, 8'hC8, 8'hFF};
  logic [9:0] gm_t [8] = '{10'h057, 10'h064, 10'h075, 10'h14D,
    10'h190, 10'h1F4, 10'h29B, 10'h3E8};
  wire logic sda = !(host_low | sda_oe);

  bbrc_top #(.DEV_ADDR(DEV), .COMP_W(8)) uut (
    .clock_i(clock_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe_o(sda_oe), .enable_pin_i(enable_pin_i), .comp_code_i(comp_code_i),
    .ref_code_o(ref_code), .ref_mv_o(ref_mv), .gm_select_o(gm_sel), .gm_us_o(gm_us),
    .freq_sel_o(freq), .switch_o(sw), .boost_mode_o(boost), .regulating_o(reg_on));
  bbrc_i2c_host host (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));

  always #12.5 clock_i = ~clock_i;

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.write_reg(DEV, a, d, ok);
    check("write ack", {11'h000, ok}, 12'h001);
    @(negedge clock_i);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    host.read_reg(DEV, a, rd, ok);
    check("read ack", {11'h000, ok}, 12'h001);
    check("read data", {4'h0, rd}, {4'h0, exp});
  endtask : rdchk
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  // Ceiling well above the roughly 28k cycles the sequence needs
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      fails++;
      conclude();
    end
  end

  initial begin
    repeat (10) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (4) @(negedge clock_i);
    check("ref code", {3'h0, ref_code}, 12'h064);
    check("ref mV", ref_mv, 12'h1F4);
    check("gm code", {9'h000, gm_sel}, 12'h005);
    check("gm uS", {2'h0, gm_us}, 12'h1F4);
    rdchk(8'h00, 8'h01);
    rdchk(8'h01, 8'h32);
    rdchk(8'h03, 8'h00);
    rdchk(8'h04, 8'h05);
    rdchk(8'h02, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(8'h01, codes[i/2]);
      wr(8'h03, {3'h0, i[0], 4'h0});
      check("ref code", {3'h0, ref_code}, {3'h0, codes[i/2], i[0]});
      check("ref mV", ref_mv, 12'(codes[i/2]) * 12'h00A + 12'(i[0]) * 12'h005);
    end
    for (int i = 0; i < 8; i++) begin
      wr(8'h04, 8'(i));
      check("gm code", {9'h000, gm_sel}, 12'(i));
      check("gm uS", {2'h0, gm_us}, {2'h0, gm_t[i]});
    end
    for (int m = 0; m < 2; m++) begin
      @(posedge clock_i);
      comp_code_i <= m ? 8'h40 : 8'hC0;
      repeat (3) @(posedge clock_i);
      n = 0;
      repeat (600) begin
        @(negedge clock_i);
        if ((m ? sw.input_high_switch : sw.output_low_switch) === 1'b1) n++;
      end
      check("active leg", {11'h000, n > 0 && n < 600}, 12'h001);
      check("boost flag", {11'h000, boost}, {11'h000, m == 0});
    end
    @(posedge clock_i);
    enable_pin_i <= 1'b0;
    repeat (6) @(negedge clock_i);
    check("pin off run", {11'h000, reg_on}, 12'h000);
    check("pin off sw", {8'h00, sw}, 12'h000);
    @(posedge clock_i);
    enable_pin_i <= 1'b1;
    repeat (6) @(negedge clock_i);
    check("pin on run", {11'h000, reg_on}, 12'h001);
    wr(8'h00, 8'h00);
    check("reg off run", {11'h000, reg_on}, 12'h000);
    check("reg off sw", {8'h00, sw}, 12'h000);
    wr(8'h00, 8'h01);
    check("reg on run", {11'h000, reg_on}, 12'h001);
    host.write_reg(7'h15, 8'h01, 8'h0A, ok);
    check("foreign ack", {11'h000, ok}, 12'h000);
    rdchk(8'h01, 8'hFF);
    check("freq sel", {9'h000, freq}, 12'h000);
    wr(8'h03, 8'h05);
    check("freq sel", {9'h000, freq}, 12'h005);
    check("ref code", {3'h0, ref_code}, 12'h1FE);
    rdchk(8'h03, 8'h05);
    // Status: regulating, buck, pin high
    rdchk(8'h05, 8'h05);
    conclude();
  end
endmodule : bbrc_top_test
